// ===== logic/mcl_map.vh
// Constants, field positions and timing figures of the command and readback link.
// Notes on behaviour
// R1: Manchester both ways, line equals bit XOR clock.
// R2: Host opens each command with sync 1100.
// R3: Clock taken from ones, zeros confirm detection.
// R4: Command 01 read, 10 write, 11 calibrate.
// R5: Command 00 reserved, device does nothing.
// R6: Read and calibrate frames are six bits.
// R7: Write frame is twelve bits, six data stored.
// R8: Host sends write data bit 0 first.
// R9: Decoder accepts 50 to 200 kb/s commands.
// R10: Reply at 100 kb/s, half duty cycle.
// R11: Reply 37 bits, zero start, error flag.
// R12: Reserved, calibration flag, gain, drive count follow.
// R13: Threshold, drain, polarity, then seven zeros.
// R14: Calibration bank: count, gain, success flag.
// R15: Config bank: polarity, drain select, threshold code.
// R16: Reserved nine-bit bank only reported on read.
// R17: Host calibrates by write, calibrate, write.
// R18: New threshold reaches comparator right after write.
// R19: Write verified by readback, mismatch sets error.
// R20: Pin high during ramp, low on success.
// R21: Bad sync or timing discards frame silently.
// R22: Host releases pin after last command bit.
`ifndef MCL_MAP_VH
`define MCL_MAP_VH
// Clock rate and link rates.
`define MCL_CLK_KHZ 25000
`define MCL_RX_MIN_KBPS 50
`define MCL_RX_MAX_KBPS 200
`define MCL_TX_KBPS 100
// Calibration timing in milliseconds.
`define MCL_CAL_RAMP_MS 17
`define MCL_CAL_STAT_MS 13
// Frame shapes.
`define MCL_SHORT_BITS 4'd6
`define MCL_LONG_BITS 4'd12
`define MCL_SYNC 4'b0011
`define MCL_REPLY_BITS 37
// Command codes as sent, first bit on the left.
`define MCL_CMD_NONE 2'b00
`define MCL_CMD_READ 2'b01
`define MCL_CMD_WRITE 2'b10
`define MCL_CMD_CAL 2'b11
// Configuration bank fields.
`define MCL_CFG_POL 5
`define MCL_CFG_DS 4
`define MCL_CFG_REF_HI 3
// Calibration bank fields.
`define MCL_CAL_CNT_HI 12
`define MCL_CAL_CNT_LO 3
`define MCL_CAL_OK 0
// Reset values of the banks.
`define MCL_CFG_RESET 6'h38
`define MCL_CALB_RESET 13'h0000
`define MCL_RSV_RESET 9'h000
`endif

// ===== logic/mcl_man_tx.v
// Manchester serialiser for the readback reply.
`timescale 1ns/100ps
`include "mcl_map.vh"
module mcl_man_tx #(
  parameter NBITS = `MCL_REPLY_BITS,
  parameter [7:0] HALF_CYC = 8'd125
) (
  // Clock and reset.
  input wire ref_clk_in,
  input wire rst_n_in,
  // Frame request.
  input wire start_in,
  input wire [NBITS-1:0] frame_in,
  // Serial line.
  output reg line_out,
  output reg busy_out
);
  reg [NBITS-1:0] shift_reg;
  reg [5:0] left_reg;
  reg [7:0] half_reg;
  reg second_reg;

  // Each bit is low then high for a one, high then low for a zero.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_reg <= {NBITS{1'b0}};
      left_reg <= 6'h00;
      half_reg <= 8'h00;
      second_reg <= 1'b0;
      line_out <= 1'b0;
      busy_out <= 1'b0;
    end else if (!busy_out) begin
      if (start_in) begin
        shift_reg <= frame_in;
        left_reg <= NBITS[5:0];
        half_reg <= 8'h00;
        second_reg <= 1'b0;
        busy_out <= 1'b1;
        line_out <= ~frame_in[0]; // R1
      end
    end else if (half_reg == HALF_CYC - 8'd1) begin
      half_reg <= 8'h00;
      if (!second_reg) begin
        second_reg <= 1'b1;
        line_out <= shift_reg[0]; // R1
      end else if (left_reg == 6'h01) begin
        busy_out <= 1'b0;
        line_out <= 1'b0;
      end else begin
        second_reg <= 1'b0;
        left_reg <= left_reg - 6'h01;
        shift_reg <= shift_reg >> 1;
        line_out <= ~shift_reg[1]; // R1
      end
    end else begin
      half_reg <= half_reg + 8'h01;
    end
  end
endmodule // mcl_man_tx

// ===== logic/mcl_link.v
// Command decoder, bank store, calibration sequencer and readback of the link.
`timescale 1ns/100ps
`include "mcl_map.vh"
module mcl_link #(
  parameter [19:0] CAL_RAMP_CYC = `MCL_CAL_RAMP_MS * `MCL_CLK_KHZ,
  parameter [19:0] CAL_STAT_CYC = `MCL_CAL_STAT_MS * `MCL_CLK_KHZ,
  parameter [5:0] CFG_RESET = `MCL_CFG_RESET,
  parameter [12:0] CALB_RESET = `MCL_CALB_RESET,
  parameter [8:0] RSV_RESET = `MCL_RSV_RESET
) (
  // Clock and reset.
  input wire ref_clk_in,
  input wire rst_n_in,
  // Calibrate and status pin.
  input wire cal_pin_in,
  output reg cal_pin_out,
  output reg cal_pin_oe_out,
  // Logic output pin.
  output reg out_pin_out,
  output reg out_pin_oe_out,
  // Analog front end.
  input wire detect_in,
  output wire [3:0] threshold_code_out,
  output reg cal_start_out,
  input wire cal_done_in,
  input wire cal_ok_in,
  input wire [9:0] led_drive_count_in,
  input wire [1:0] gain_step_bits_in,
  // Bank state.
  output wire [5:0] output_config_bank_out,
  output wire [12:0] calibration_result_bank_out,
  output wire error_flag_out
);
  // Bit period limits and the reply half bit in clock cycles.
  localparam integer T_MIN_I = `MCL_CLK_KHZ / `MCL_RX_MAX_KBPS;
  localparam integer T_MAX_I = `MCL_CLK_KHZ / `MCL_RX_MIN_KBPS;
  localparam integer TX_HALF_I = `MCL_CLK_KHZ / `MCL_TX_KBPS / 2;
  localparam [9:0] T_MIN = T_MIN_I[9:0];
  localparam [9:0] T_MAX = T_MAX_I[9:0];
  localparam [7:0] TX_HALF = TX_HALF_I[7:0];
  // States.
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_MEAS = 3'd1;
  localparam [2:0] S_BITS = 3'd2;
  localparam [2:0] S_EXEC = 3'd3;
  localparam [2:0] S_VERIFY = 3'd4;
  localparam [2:0] S_RAMP = 3'd5;
  localparam [2:0] S_STAT = 3'd6;
  localparam [2:0] S_TX = 3'd7;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg cal_prev_reg;
  reg [10:0] cnt_reg;
  reg [10:0] cnt_next;
  reg [9:0] period_reg;
  reg [9:0] period_next;
  reg [11:0] bits_reg;
  reg [11:0] bits_next;
  reg [3:0] nbits_reg;
  reg [3:0] nbits_next;
  reg [19:0] tmr_reg;
  reg [5:0] cfg_reg;
  reg [5:0] wr_data_reg;
  reg err_reg;
  reg [12:0] calb_reg;
  reg [8:0] rsv_reg;
  reg cal_pass_reg;
  reg tx_start;
  wire tx_line;
  wire tx_busy;
  wire rise;
  wire fall;
  wire [10:0] early_lim;
  wire [10:0] late_lim;
  wire [1:0] cmd;
  wire [36:0] reply;
  wire drv_level;

  // Edge detection on the command pin.
  assign rise = cal_pin_in & ~cal_prev_reg;
  assign fall = ~cal_pin_in & cal_prev_reg;

  // Window for a mid-bit edge, three quarters to five quarters of a bit.
  assign early_lim = {1'b0, period_reg} - {3'b000, period_reg[9:2]};
  assign late_lim = {1'b0, period_reg} + {3'b000, period_reg[9:2]};

  // Command bits as sent, first one on the left.
  assign cmd = {bits_reg[4], bits_reg[5]}; // R4

  // Reply frame, element zero goes out first.
  assign reply = {7'h00, cfg_reg[`MCL_CFG_POL], cfg_reg[`MCL_CFG_DS], // R13
                  cfg_reg[`MCL_CFG_REF_HI:0], // R13
                  calb_reg[`MCL_CAL_CNT_HI:`MCL_CAL_CNT_LO], // R12
                  calb_reg[2:1], calb_reg[`MCL_CAL_OK], // R12
                  rsv_reg, err_reg, 1'b0}; // R11

  // Bank outputs and the live threshold code.
  assign threshold_code_out = cfg_reg[`MCL_CFG_REF_HI:0]; // R18
  assign output_config_bank_out = cfg_reg;
  assign calibration_result_bank_out = calb_reg;
  assign error_flag_out = err_reg;

  // Decides whether the frame is good: sync, length and code.
  function [2:0] mcl_dispatch;
    input [3:0] sync;
    input [1:0] code;
    input [3:0] nbits;
    begin
      mcl_dispatch = S_IDLE;
      if (sync == `MCL_SYNC) begin // R3 R21
        if (nbits == `MCL_SHORT_BITS && code == `MCL_CMD_READ) begin // R6
          mcl_dispatch = S_TX;
        end else if (nbits == `MCL_SHORT_BITS && code == `MCL_CMD_CAL) begin // R6
          mcl_dispatch = S_RAMP;
        end else if (nbits == `MCL_LONG_BITS && code == `MCL_CMD_WRITE) begin // R7
          mcl_dispatch = S_VERIFY;
        end
      end
    end
  endfunction

  // Receive and sequencing state machine.
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    period_next = period_reg;
    bits_next = bits_reg;
    nbits_next = nbits_reg;
    tx_start = 1'b0;
    case (state_reg)
      S_IDLE: begin
        cnt_next = 11'h000;
        if (rise) begin
          bits_next = 12'h001;
          state_next = S_MEAS; // R3
        end
      end
      S_MEAS: begin
        cnt_next = cnt_reg + 11'h001;
        if (rise) begin
          if (cnt_next >= {1'b0, T_MIN} && cnt_next <= {1'b0, T_MAX}) begin // R9
            period_next = cnt_next[9:0]; // R3
            bits_next = 12'h003;
            nbits_next = 4'd2;
            cnt_next = 11'h000;
            state_next = S_BITS;
          end else begin
            state_next = S_IDLE; // R21
          end
        end else if (cnt_reg > {1'b0, T_MAX}) begin
          state_next = S_IDLE; // R21
        end
      end
      S_BITS: begin
        cnt_next = cnt_reg + 11'h001;
        if ((rise || fall) && cnt_reg >= early_lim) begin
          if (nbits_reg < `MCL_LONG_BITS) begin
            bits_next[nbits_reg] = cal_pin_in; // R1
          end
          if (nbits_reg <= `MCL_LONG_BITS) begin
            nbits_next = nbits_reg + 4'd1;
          end
          cnt_next = 11'h000;
        end else if (cnt_reg > late_lim) begin
          state_next = S_EXEC;
        end
      end
      S_EXEC: begin
        state_next = mcl_dispatch(bits_reg[3:0], cmd, nbits_reg); // R5 R21
        if (state_next == S_TX) begin
          tx_start = 1'b1; // R10
        end
      end
      S_VERIFY: begin
        state_next = S_IDLE;
      end
      S_RAMP: begin
        if (cal_done_in || tmr_reg >= CAL_RAMP_CYC - 20'h00001) begin
          state_next = S_STAT; // R20
        end
      end
      S_STAT: begin
        if (tmr_reg >= CAL_STAT_CYC - 20'h00001) begin
          state_next = S_IDLE; // R20
        end
      end
      S_TX: begin
        if (!tx_busy && !tx_start) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // State and decoder registers.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= S_IDLE;
      cal_prev_reg <= 1'b0;
      cnt_reg <= 11'h000;
      period_reg <= 10'h000;
      bits_reg <= 12'h000;
      nbits_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cal_prev_reg <= cal_pin_in;
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      bits_reg <= bits_next;
      nbits_reg <= nbits_next;
    end
  end

  // Configuration bank write and readback check.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg <= CFG_RESET;
      wr_data_reg <= 6'h00;
      err_reg <= 1'b0;
    end else if (state_reg == S_EXEC && state_next == S_VERIFY) begin
      cfg_reg <= bits_reg[11:6]; // R7 R15 R18
      wr_data_reg <= bits_reg[11:6];
    end else if (state_reg == S_VERIFY) begin
      err_reg <= (cfg_reg != wr_data_reg); // R19
    end
  end

  // Calibration timer, start pulse and result capture.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmr_reg <= 20'h00000;
      cal_start_out <= 1'b0;
      calb_reg <= CALB_RESET;
      cal_pass_reg <= 1'b0;
    end else begin
      cal_start_out <= (state_reg == S_EXEC && state_next == S_RAMP);
      if (state_reg != state_next) begin
        tmr_reg <= 20'h00000;
      end else begin
        tmr_reg <= tmr_reg + 20'h00001;
      end
      if (state_reg == S_RAMP && state_next == S_STAT) begin
        cal_pass_reg <= cal_done_in & cal_ok_in; // R20
        calb_reg[`MCL_CAL_OK] <= cal_done_in & cal_ok_in; // R14
        calb_reg[2:1] <= gain_step_bits_in; // R14
        if (cal_done_in && cal_ok_in) begin
          calb_reg[`MCL_CAL_CNT_HI:`MCL_CAL_CNT_LO] <= led_drive_count_in; // R14
        end
      end
    end
  end

  // Reserved bank holds its reset contents; no command writes it.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsv_reg <= RSV_RESET;
    end else begin
      rsv_reg <= rsv_reg; // R16
    end
  end

  // Status drive on the calibrate pin while calibrating.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_pin_out <= 1'b0;
      cal_pin_oe_out <= 1'b0;
    end else begin
      cal_pin_oe_out <= (state_next == S_RAMP || state_next == S_STAT); // R20 R22
      cal_pin_out <= (state_next == S_RAMP) ||
                     (state_next == S_STAT && !(state_reg == S_RAMP ?
                       (cal_done_in & cal_ok_in) : cal_pass_reg)); // R20
    end
  end

  // Reply serialiser.
  mcl_man_tx #(
    .NBITS(`MCL_REPLY_BITS),
    .HALF_CYC(TX_HALF)
  ) u_tx (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(tx_start),
    .frame_in(reply),
    .line_out(tx_line),
    .busy_out(tx_busy)
  );

  // Level on the output pin: reply while reading, else detection with polarity.
  assign drv_level = tx_busy ? tx_line : (detect_in ^ cfg_reg[`MCL_CFG_POL]); // R10 R15

  // Drive type: push-pull drives both levels, open drain only pulls low.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_pin_out <= 1'b0;
      out_pin_oe_out <= 1'b0;
    end else if (cfg_reg[`MCL_CFG_DS]) begin
      out_pin_out <= drv_level; // R15
      out_pin_oe_out <= 1'b1;
    end else begin
      out_pin_out <= 1'b0;
      out_pin_oe_out <= ~drv_level; // R15
    end
  end
endmodule // mcl_link

// ===== bench/mcl_host_model.sv
// Host model: sends Manchester commands and captures the readback reply.
`timescale 1ns/100ps
module mcl_host_model (
  // Clock and wires.
  input wire ref_clk_in,
  input wire out_wire_in,
  // Host drive of the calibrate wire.
  output reg host_drv_out,
  output reg host_oe_out
);
  initial begin
    host_drv_out = 1'b0;
    host_oe_out = 1'b0;
  end

  // Sends n bits, b[0] first; a one is low then high, a zero high then low.
  task send(input [11:0] b, input integer n, input integer t);
    integer i;
    begin
      @(negedge ref_clk_in);
      host_oe_out = 1'b1;
      for (i = 0; i < n; i++) begin
        host_drv_out = ~b[i];
        repeat (t / 2) @(negedge ref_clk_in);
        host_drv_out = b[i];
        repeat (t - t / 2) @(negedge ref_clk_in);
      end
      host_oe_out = 1'b0;
      host_drv_out = 1'b0;
    end
  endtask

  // Waits for the reply's first rise, then takes each bit from its second half.
  task rx(output reg [36:0] r, output reg bad);
    integer i, w;
    reg a;
    begin
      bad = 1'b0;
      w = 0;
      while (out_wire_in !== 1'b1 && w < 20000) begin
        @(posedge ref_clk_in);
        w++;
      end
      if (w >= 20000)
        bad = 1'b1;
      repeat (62) @(posedge ref_clk_in);
      for (i = 0; i < 37; i++) begin
        a = out_wire_in;
        repeat (125) @(posedge ref_clk_in);
        r[i] = out_wire_in;
        if (a === r[i])
          bad = 1'b1;
        repeat (125) @(posedge ref_clk_in);
      end
    end
  endtask
endmodule // mcl_host_model

// ===== bench/mcl_link_properties.sv
// Assertion checker for the link's pins and banks.
`timescale 1ns/100ps
module mcl_link_properties #(
  parameter [19:0] CAL_RAMP_CYC = 20'd425000,
  parameter [19:0] CAL_STAT_CYC = 20'd325000
) (
  // Clock and reset.
  input wire ref_clk_in,
  input wire rst_n_in,
  // Pins.
  input wire cal_pin_out,
  input wire cal_pin_oe_out,
  input wire out_pin_oe_out,
  // Front end and banks.
  input wire [3:0] threshold_code_out,
  input wire cal_start_out,
  input wire [5:0] output_config_bank_out,
  input wire [12:0] calibration_result_bank_out,
  input wire error_flag_out
);
  localparam [20:0] DRIVE_MAX = CAL_RAMP_CYC + CAL_STAT_CYC + 20'd8;
  reg [20:0] drive_cnt_reg;

  // Length of the current stretch with the calibrate pin driven.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      drive_cnt_reg <= 21'h0;
    else
      drive_cnt_reg <= cal_pin_oe_out ? drive_cnt_reg + 21'h1 : 21'h0;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_thr_tracks_cfg: assert property (
    threshold_code_out == output_config_bank_out[3:0]) else $error("threshold not config");
  a_cal_start_pulse: assert property (
    cal_start_out |=> !cal_start_out [*8]) else $error("ramp start not a single pulse");
  a_ramp_pin_high: assert property (
    cal_start_out |-> ##[0:2] (cal_pin_oe_out && cal_pin_out)) else $error("pin not high");
  a_cfg_hold_cal: assert property (
    cal_pin_oe_out |=> $stable(output_config_bank_out)) else $error("config moved in cal");
  a_calb_read_only: assert property (
    !cal_pin_oe_out |-> $stable(calibration_result_bank_out)) else $error("cal bank moved");
  a_ok_status_low: assert property (
    $rose(calibration_result_bank_out[0]) |-> ##[0:2] (cal_pin_oe_out && !cal_pin_out))
    else $error("success without low status");
  a_no_verify_error: assert property (
    !error_flag_out) else $error("write verify error raised");
  a_push_pull_drive: assert property (
    output_config_bank_out[4] ##1 output_config_bank_out[4] |-> out_pin_oe_out)
    else $error("push-pull output not driven");
  a_drive_bounded: assert property (
    drive_cnt_reg <= DRIVE_MAX) else $error("calibrate pin held too long");

  c_cal: cover property (cal_start_out);
  c_cal_ok: cover property ($rose(calibration_result_bank_out[0]));
  c_cfg_write: cover property ($changed(output_config_bank_out));
  c_open_drain: cover property (out_pin_oe_out && !output_config_bank_out[4]);
endmodule // mcl_link_properties

bind mcl_link mcl_link_properties #(.CAL_RAMP_CYC(CAL_RAMP_CYC), .CAL_STAT_CYC(CAL_STAT_CYC))
  u_props (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cal_pin_out(cal_pin_out),
  .cal_pin_oe_out(cal_pin_oe_out), .out_pin_oe_out(out_pin_oe_out),
  .threshold_code_out(threshold_code_out), .cal_start_out(cal_start_out),
  .output_config_bank_out(output_config_bank_out),
  .calibration_result_bank_out(calibration_result_bank_out), .error_flag_out(error_flag_out));

// ===== bench/tb.sv
// Self-checking bench for the command and readback link.
`timescale 1ns/100ps
`include "mcl_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  reg ref_clk_in, rst_n_in, detect_in, cal_done_in, cal_ok_in, bad;
  reg [9:0] led_reg;
  reg [1:0] gain_reg;
  reg [5:0] cfg_exp;
  reg [12:0] calb_exp;
  reg [36:0] rep;
  reg [31:0] r32;
  integer failures, samples_checked, k, t, w;
  wire cal_w, out_w, cal_pin_out, cal_pin_oe_out, out_pin_out, out_pin_oe_out;
  wire host_drv, host_oe, cal_start_out, error_flag_out;
  wire [3:0] thr;
  wire [5:0] cfg_out;
  wire [12:0] calb_out;

  // Wire levels: calibrate pin pulled low, output pin pulled high.
  assign cal_w = cal_pin_oe_out ? cal_pin_out : (host_oe ? host_drv : 1'b0);
  assign out_w = out_pin_oe_out ? out_pin_out : 1'b1;

  mcl_link #(.CAL_RAMP_CYC(20'd200), .CAL_STAT_CYC(20'd150)) DUT (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .cal_pin_in(cal_w), .cal_pin_out(cal_pin_out),
    .cal_pin_oe_out(cal_pin_oe_out), .out_pin_out(out_pin_out),
    .out_pin_oe_out(out_pin_oe_out), .detect_in(detect_in), .threshold_code_out(thr),
    .cal_start_out(cal_start_out), .cal_done_in(cal_done_in), .cal_ok_in(cal_ok_in),
    .led_drive_count_in(led_reg), .gain_step_bits_in(gain_reg),
    .output_config_bank_out(cfg_out), .calibration_result_bank_out(calb_out),
    .error_flag_out(error_flag_out));
  mcl_host_model host (.ref_clk_in(ref_clk_in), .out_wire_in(out_w),
    .host_drv_out(host_drv), .host_oe_out(host_oe));

  // Command frame in send order: sync, command bits, data bit 0 first.
  function [11:0] fw(input [1:0] c, input [5:0] v);
    fw = {v, c[0], c[1], `MCL_SYNC};
  endfunction

  // Expected reply, first bit of the frame in bit 0.
  function [36:0] reply(input [5:0] c, input [12:0] b);
    reply = {7'h00, c[5], c[4], c[3:0], b[12:3], b[2:1], b[0], `MCL_RSV_RESET, 2'h0};
  endfunction

  // Sends one frame; a read frame is followed by capture of the reply.
  task cmd(input [11:0] b, input integer n, input integer tt);
    begin
      detect_in = cfg_exp[5];
      host.send(b, n, tt);
      if (b[5:4] == 2'b10 && n == 6) begin
        host.rx(rep, bad);
        `CHK("reply", reply(cfg_exp, calb_exp), rep)
        `CHK("duty", 1'b0, bad)
      end else
        repeat (2 * tt + 100) @(negedge ref_clk_in);
    end
  endtask

  task conclude;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    failures++;
    conclude;
  end

  initial begin
    {rst_n_in, detect_in, cal_done_in, cal_ok_in} = 4'h0;
    led_reg = 10'h000;
    gain_reg = 2'h0;
    failures = 0;
    samples_checked = 0;
    cfg_exp = `MCL_CFG_RESET;
    calb_exp = `MCL_CALB_RESET;
    r32 = $urandom(31906);
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    `CHK("config", cfg_exp, cfg_out)
    `CHK("calbank", calb_exp, calb_out)
    // Writes at both rate limits and at random rates, some read back.
    for (k = 0; k < 5; k++) begin
      r32 = $urandom;
      t = (k == 0) ? 125 : (k == 1) ? 500 : 125 + r32[8:0] % 376;
      cmd(fw(`MCL_CMD_WRITE, r32[15:10]), 12, t);
      cfg_exp = r32[15:10];
      `CHK("config", cfg_exp, cfg_out)
      `CHK("threshold", cfg_exp[3:0], thr)
      detect_in = r32[20];
      repeat (3) @(negedge ref_clk_in);
      `CHK("out level", detect_in ^ cfg_exp[5], out_w)
      if (k == 0 || k == 3)
        cmd(fw(`MCL_CMD_READ, 6'h00), 6, 250);
    end
    // Reserved code, bad sync, short write and too fast a rate are dropped.
    for (k = 0; k < 4; k++) begin
      r32 = $urandom;
      case (k)
        0: cmd(fw(`MCL_CMD_NONE, r32[5:0]), 6, 250);
        1: cmd(fw(`MCL_CMD_WRITE, r32[5:0]) ^ 12'h004, 12, 250);
        2: cmd(fw(`MCL_CMD_WRITE, r32[5:0]), 6, 250);
        default: cmd(fw(`MCL_CMD_WRITE, r32[5:0]), 12, 100);
      endcase
      `CHK("config kept", cfg_exp, cfg_out)
    end
    // Calibration failing by the front end's answer, failing by ramp timeout, then succeeding.
    for (k = 0; k < 3; k++) begin
      r32 = $urandom;
      cal_ok_in = (k == 2);
      led_reg = r32[9:0];
      gain_reg = r32[11:10];
      host.send(fw(`MCL_CMD_CAL, 6'h00), 6, 250);
      w = 0;
      while (cal_start_out !== 1'b1 && w < 1000) begin
        @(negedge ref_clk_in);
        w++;
      end
      `CHK("ramp start", 1'b1, cal_start_out)
      repeat (20) @(negedge ref_clk_in);
      `CHK("ramp level", 1'b1, cal_w)
      if (k == 1) begin
        repeat (200) @(negedge ref_clk_in);
      end else begin
        cal_done_in = 1'b1;
        @(negedge ref_clk_in);
        cal_done_in = 1'b0;
      end
      repeat (20) @(negedge ref_clk_in);
      `CHK("status level", k != 2, cal_w)
      repeat (200) @(negedge ref_clk_in);
      `CHK("released", 1'b0, cal_pin_oe_out)
      calb_exp[2:1] = gain_reg;
      if (k == 2)
        calb_exp = {led_reg, gain_reg, 1'b1};
      `CHK("gain", calb_exp[2:1], calb_out[2:1])
    end
    `CHK("calbank", calb_exp, calb_out)
    r32 = $urandom;
    cmd(fw(`MCL_CMD_WRITE, r32[5:0]), 12, 250);
    cfg_exp = r32[5:0];
    cmd(fw(`MCL_CMD_READ, 6'h00), 6, 250);
    conclude;
  end
endmodule // tb
